// ---- rtl/sbus_pkg.sv ----
// Constants shared by the serial control bus slave
package sbus_pkg;
    // System clock rate
    localparam int CLK_HZ = 25000000;
    // Longest time from select high to reply line released, in ns
    localparam int REL_MAX_NS = 1000;
    // Cycles to release, rounded down, at least one
    localparam int REL_CYC_RAW = (REL_MAX_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int REL_CYC = (REL_CYC_RAW < 1) ? 1 : REL_CYC_RAW;
    // Synchroniser delay is 2 cycles plus one for edge detection
    localparam int SYNC_LAT = 3;
    // Byte width and bit counter width
    localparam int BYTE_W = 8;
    localparam int CNT_W = 5;
    // Reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
    // Bit count of a whole one-byte and two-byte command
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h08;
    localparam logic [CNT_W-1:0] CNT_TWO = 5'h10;
endpackage

// ---- rtl/sync2.sv ----
// Two flip-flop synchroniser for a pin input
module sync2 #(
    // Level held while reset is applied; match the pin's idle level
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Pin level and its synchronised copy
    input wire logic din,
    output logic dout
);
    logic meta_ff;

    // First stage read only by the second
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_ff <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_ff <= din;
            dout <= meta_ff;
        end
    end
endmodule

// ---- rtl/serial_control_bus_slave.sv ----
// Device end of the four-wire serial control bus
module serial_control_bus_slave
    import sbus_pkg::*;
(
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Serial bus pins
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic command_data_in,
    output logic reply_data_out,
    output logic reply_data_oe,
    // Reply bytes to send, two bytes, first in high byte
    input wire logic [15:0] reply_word,
    // Executed command to the device core
    output logic cmd_valid_ff,
    output logic cmd_two_ff,
    output logic [7:0] cmd_addr_ff,
    output logic [7:0] cmd_data_ff
);
    // Width of the release budget counter
    localparam int REL_W = $clog2(REL_CYC + 1);

    // Frame phases seen from the system clock side
    typedef enum logic [1:0] {
        FR_IDLE,
        FR_SELECTED,
        FR_CLOSING
    } frame_t;

    // Synchronised pin levels
    logic csn_s;
    logic sck_s;
    logic cdi_s;
    // Previous synchronised levels
    logic csn_d_ff;
    logic sck_d_ff;
    // One-cycle edge strobes and the whole-byte count flag
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic whole_cnt;
    // Frame tracking
    frame_t frame_ff;
    logic sel;
    logic [REL_W-1:0] rel_ff;
    // Command and reply shifters
    logic [15:0] shift_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [15:0] tx_ff;
    logic first_fall_ff;

    // All three pins cross into the system clock; select idles high
    sync2 #(.RST_VAL(1'b1)) u_sync_cs (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(chip_select_n),
        .dout(csn_s)
    );
    sync2 #(.RST_VAL(1'b0)) u_sync_ck (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(serial_clk),
        .dout(sck_s)
    );
    sync2 #(.RST_VAL(1'b0)) u_sync_di (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(command_data_in),
        .dout(cdi_s)
    );

    // Select history at idle level, so reset gives no false edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            csn_d_ff <= 1'b1;
        end else begin
            csn_d_ff <= csn_s;
        end
    end

    // Clock history; a stray edge while idle is ignored anyway
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sck_d_ff <= 1'b0;
        end else begin
            sck_d_ff <= sck_s;
        end
    end

    // Edges only, so commands work at either clock idle level; the reply needs the clock idling high
    assign sck_rise = sck_s & ~sck_d_ff;
    assign sck_fall = ~sck_s & sck_d_ff;
    assign cs_fall = ~csn_s & csn_d_ff;
    assign cs_rise = csn_s & ~csn_d_ff;
    assign whole_cnt = (cnt_ff == CNT_ONE) || (cnt_ff == CNT_TWO);

    // Frame phase; closing runs out the release budget
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frame_ff <= FR_IDLE;
        end else begin
            case (frame_ff)
                FR_IDLE: begin
                    if (cs_fall) begin
                        frame_ff <= FR_SELECTED;
                    end
                end
                FR_SELECTED: begin
                    if (cs_rise) begin
                        frame_ff <= FR_CLOSING;
                    end
                end
                FR_CLOSING: begin
                    // A host that skips the gap still gets its frame
                    if (cs_fall) begin
                        frame_ff <= FR_SELECTED;
                    end else if (rel_ff == '0) begin
                        frame_ff <= FR_IDLE;
                    end
                end
                default: begin
                    frame_ff <= FR_IDLE;
                end
            endcase
        end
    end

    // Selected while the frame is open
    assign sel = (frame_ff == FR_SELECTED);

    // Release budget left after select rises, less the sync delay
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rel_ff <= '0;
        end else if (cs_rise && sel) begin
            rel_ff <= REL_W'(REL_CYC - SYNC_LAT);
        end else if (rel_ff != '0) begin
            rel_ff <= rel_ff - REL_W'(1);
        end
    end

    // Command shifter, MSB first, bits taken on rising clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift_ff <= 16'h0000;
        end else if (cs_fall) begin
            shift_ff <= 16'h0000;
        end else if (sel && sck_rise) begin
            shift_ff <= {shift_ff[14:0], cdi_s};
        end
    end

    // Bit counter saturates so long frames cannot wrap to a legal count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_ff <= CNT_RST;
        end else if (cs_fall) begin
            cnt_ff <= CNT_RST;
        end else if (sel && sck_rise && (cnt_ff != 5'h1F)) begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end

    // Execute strobe at select rising; partial bytes dropped
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_valid_ff <= 1'b0;
        end else begin
            cmd_valid_ff <= cs_rise && sel && whole_cnt;
        end
    end

    // Command fields held until the next executed command
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_two_ff <= 1'b0;
            cmd_addr_ff <= BYTE_RST;
            cmd_data_ff <= BYTE_RST;
        end else if (cs_rise && sel) begin
            if (cnt_ff == CNT_ONE) begin
                cmd_two_ff <= 1'b0;
                cmd_addr_ff <= shift_ff[7:0];
                cmd_data_ff <= BYTE_RST;
            end else if (cnt_ff == CNT_TWO) begin
                cmd_two_ff <= 1'b1;
                cmd_addr_ff <= shift_ff[15:8];
                cmd_data_ff <= shift_ff[7:0];
            end
        end
    end

    // Reply word loaded at select fall, advanced after the first fall
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_ff <= 16'h0000;
        end else if (cs_fall) begin
            tx_ff <= reply_word;
        end else if (sel && sck_fall && first_fall_ff) begin
            tx_ff <= {tx_ff[14:0], 1'b0};
        end
    end

    // Marks that the first falling clock of the frame has passed
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            first_fall_ff <= 1'b0;
        end else if (cs_fall) begin
            first_fall_ff <= 1'b0;
        end else if (sel && sck_fall) begin
            first_fall_ff <= 1'b1;
        end
    end

    // Reply bit moves only after a fall, so the host reads it on the rise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reply_data_out <= 1'b0;
        end else if (cs_fall) begin
            reply_data_out <= 1'b0;
        end else if (sel && sck_fall) begin
            if (first_fall_ff) begin
                reply_data_out <= tx_ff[14];
            end else begin
                reply_data_out <= tx_ff[15];
            end
        end
    end

    // Drive enable: on after a falling clock, off once the frame closes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reply_data_oe <= 1'b0;
        end else if (sel && sck_fall && !cs_rise) begin
            reply_data_oe <= 1'b1;
        end else if (cs_rise || !sel) begin
            // Sync delay already spent, so the drop is immediate
            reply_data_oe <= 1'b0;
        end
    end
endmodule

// ---- bench/sbus_assertions.sv ----
// Port checks for the serial control bus slave
module sbus_chk (
    input wire logic clk_sys, rst, chip_select_n, serial_clk,
    input wire logic reply_data_out, reply_data_oe, cmd_valid_ff, cmd_two_ff,
    input wire logic [7:0] cmd_addr_ff, cmd_data_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_exec_on_rise: assert property (cmd_valid_ff |-> $past(chip_select_n, 3))
        else $error("exec while selected");
    a_valid_pulse: assert property (cmd_valid_ff |=> !cmd_valid_ff)
        else $error("long pulse");
    a_oe_release: assert property ($rose(chip_select_n) |-> ##[1:25] !reply_data_oe)
        else $error("late release");
    a_oe_start: assert property ($rose(reply_data_oe) |->
        !$past(serial_clk, 2) && !$past(chip_select_n, 2)) else $error("early drive");
    a_out_moves: assert property ($changed(reply_data_out) && reply_data_oe |->
        !$past(serial_clk, 2)) else $error("reply moved off fall");
    a_fields_hold: assert property (!cmd_valid_ff |->
        $stable({cmd_two_ff, cmd_addr_ff, cmd_data_ff})) else $error("fields moved");
    a_one_byte: assert property (cmd_valid_ff && !cmd_two_ff |-> cmd_data_ff == 8'h00)
        else $error("stale data byte");
    c_two: cover property (cmd_valid_ff && cmd_two_ff);
    c_one: cover property (cmd_valid_ff && !cmd_two_ff);
    c_rel: cover property ($fell(reply_data_oe));
endmodule

// ---- bench/sbus_host.sv ----
// Bus master model driving the serial control bus pins
module sbus_host (
    input wire logic clk_sys, reply_data_out, reply_data_oe,
    output logic chip_select_n, serial_clk, command_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b1;
        command_data_in = 1'b0;
    end
    // Move pins just after a system edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // One frame, n bits MSB first; reply gathered before each rise
    task automatic xfer(input int n, input logic [15:0] d, input logic idle,
                        output logic [15:0] rx);
        rx = 16'h0000;
        serial_clk = idle;
        step(30);
        chip_select_n = 1'b0;
        step(4);
        for (int i = 15; i > 15 - n; i--) begin
            serial_clk = 1'b0;
            command_data_in = d[i];
            step(4);
            rx = {rx[14:0], reply_data_oe ? reply_data_out : 1'bz};
            serial_clk = 1'b1;
            step(4);
        end
        serial_clk = idle;
        step(4);
        chip_select_n = 1'b1;
        command_data_in = ~command_data_in; // No stale level left behind
    endtask
endmodule

// ---- bench/serial_control_bus_slave_tb.sv ----
// Self-checking bench for the serial control bus slave
module serial_control_bus_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst = 1'b1, chip_select_n, serial_clk, command_data_in;
    logic reply_data_out, reply_data_oe, cmd_valid_ff, cmd_two_ff;
    logic [7:0] cmd_addr_ff, cmd_data_ff;
    logic [15:0] reply_word = 16'h0000, d, rx;
    int mismatches = 0, n_checks = 0, seen = 0, n, k;
    int nb[6] = '{8, 16, 7, 0, 12, 16};
    always #20 clk_sys = ~clk_sys;
    // Count executed commands
    always @(posedge clk_sys) if (cmd_valid_ff === 1'b1) seen++;
    serial_control_bus_slave dut_u (.*);
    sbus_host host_u (.*);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Whole one- or two-byte frames execute once, others never
    function automatic logic [15:0] exp_execs(input int nbits);
        return (nbits == 8 || nbits == 16) ? 16'h0001 : 16'h0000;
    endfunction
    task automatic finish_test;
        if (mismatches == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Corner bit counts first, then random whole frames
    initial begin
        void'($urandom(32'h5BB97152));
        repeat (8) @(posedge clk_sys);
        #2 rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            n = (i < 6) ? nb[i] : (($urandom % 2) ? 16 : 8);
            d = 16'($urandom);
            reply_word = 16'($urandom);
            k = seen;
            host_u.xfer(n, d, i[0], rx);
            repeat (6) @(posedge clk_sys);
            #2;
            check(16'(seen - k), exp_execs(n));
            if (n == 8 || n == 16) begin
                check({cmd_two_ff, 7'h00, cmd_addr_ff}, {n == 16, 7'h00, d[15:8]});
                check({8'h00, cmd_data_ff}, (n == 16) ? {8'h00, d[7:0]} : 16'h0000);
            end
            if (i[0]) check(rx, reply_word >> (16 - n));
        end
        finish_test();
    end
    // Watchdog
    initial begin
        #500000;
        mismatches++;
        finish_test();
    end
endmodule
bind serial_control_bus_slave sbus_chk chk_u (.*);
